// *** rtl/lock_ctrl_pkg.sv ***
// Shared constants and carrier types for the locked sequence and trap entry control.
package lock_ctrl_pkg;
   localparam int unsigned PRIO_W       = 4;
   localparam int unsigned VEC_W        = 8;
   localparam int unsigned PAGE_W       = 10;
   localparam int unsigned SEG_W        = 8;
   localparam int unsigned ADDR_W       = 16;
   localparam int unsigned PAGE_OFS_W   = 14;
   localparam int unsigned PHYS_W       = 24;
   localparam int unsigned CNT_W        = 3;
   localparam int unsigned LOCK_MAX     = 4;
   localparam int unsigned STATE_WORDS  = 3;
   localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
   localparam logic [1:0] WORD_ZERO      = 2'h0;
   localparam logic [1:0] WORD_LAST      = 2'h2;

   // Prefix kinds decoded by the pipeline.
   typedef enum logic [2:0] {
      PFX_NONE, PFX_ATOMIC, PFX_PAGE, PFX_SEG, PFX_REG, PFX_PAGE_REG, PFX_SEG_REG
   } prefix_e;

   // One instruction completing execution.
   typedef struct packed {
      logic              done;
      prefix_e           kind;
      logic [CNT_W-1:0]  count;
      logic [PAGE_W-1:0] page;
      logic [SEG_W-1:0]  seg;
      logic              idle;
      logic              interrupt_return_instr;
   } instr_s;

   // Pending requests from arbitration.
   typedef struct packed {
      logic              irq;
      logic [PRIO_W-1:0] irq_prio;
      logic [VEC_W-1:0]  irq_vec;
      logic              peripheral_event_transfer;
      logic              trap_a;
      logic [VEC_W-1:0]  trap_a_vec;
      logic              trap_b;
      logic [VEC_W-1:0]  trap_b_vec;
   } req_s;
endpackage : lock_ctrl_pkg

// *** rtl/locked_sequence_extension_control.sv ***
// Trap and interrupt entry/return control with locked-sequence address overrides.
//
// Summary of operation
// - Interrupt taken only if priority exceeds CPU level.
// - Traps taken regardless of CPU priority.
// - Entry pushes state, then branches to vector.
// - Return pops state, then resumes at origin.
// - Multiply and divide stay interruptible.
// - Lock prefix covers one to four instructions.
// - Lock blocks interrupts, event transfers, class A traps.
// - Class B traps still break locked sequence.
// - Block is immediate; next instruction follows directly.
// - Multi-cycle instructions count once; any type allowed.
// - Normal addressing: page pointer plus 14-bit offset.
// - Page prefix substitutes page number temporarily.
// - Segment prefix uses full 16-bit offset.
// - Short modes normally decode to standard registers.
// - Register prefix steers short modes to extended space.
// - Combined prefixes apply both overrides together.
// - All override prefixes block like lock prefix.
// - Nested prefix reloads the extension counter.
// - Idle inside lock ignores event transfers.
`timescale 1ns/1ps
module locked_sequence_extension_control
   import lock_ctrl_pkg::*;
#(
   parameter int unsigned MAX_COUNT = LOCK_MAX
) (
   // Clock and reset.
   input  wire logic                   i_clk,
   input  wire logic                   i_srst,
   // Pipeline side.
   input  wire instr_s                 i_instr,
   input  wire logic                   i_mul_busy,
   input  wire logic [PRIO_W-1:0]      i_cpu_prio,
   input  wire logic [ADDR_W-1:0]      i_op_addr,
   input  wire logic                   i_short_mode,
   input  wire logic [1:0][PAGE_W-1:0] i_page_ptr,
   input  wire logic [1:0][PAGE_W-1:0] i_page_ptr_hi,
   input  wire logic                   i_stack_ready,
   // Arbitration side.
   input  wire req_s                   i_req,
   // Outputs.
   output logic                        o_locked,
   output logic                        o_take_irq,
   output logic                        o_take_trap,
   output logic                        o_take_pec,
   output logic                        o_abort_mul,
   output logic                        o_push,
   output logic                        o_pop,
   output logic [1:0]                  o_stack_word,
   output logic                        o_branch,
   output logic [VEC_W-1:0]            o_vector,
   output logic                        o_resume,
   output logic [PHYS_W-1:0]           o_phys_addr,
   output logic                        o_ext_reg_space
);

   // The extension counter is CNT_W bits wide, so a longer cover could not be counted.
   if ((MAX_COUNT < 1) || (MAX_COUNT >= (1 << CNT_W))) begin : g_bad_count
      $error("MAX_COUNT must lie between one and the counter range");
   end

   // Longest cover that one prefix may load, and the step of the stack word index.
   localparam logic [CNT_W-1:0] CNT_MAX  = CNT_W'(MAX_COUNT);
   localparam logic [1:0]       WORD_ONE = 2'h1;

   typedef enum logic [1:0] {ST_RUN, ST_PUSH, ST_POP} ctl_e;

   ctl_e              state_q;
   logic [CNT_W-1:0]  cnt_q;
   logic              page_ov_q;
   logic              seg_ov_q;
   logic              reg_ov_q;
   logic [PAGE_W-1:0] page_q;
   logic [SEG_W-1:0]  seg_q;
   logic [1:0]        word_q;
   logic [VEC_W-1:0]  vec_q;
   logic              idle_lock_q;

   logic pfx;
   logic lock_now;
   logic cnt_dec;
   logic trap_b_ok;
   logic trap_a_ok;
   logic irq_ok;
   logic pec_ok;
   logic take_any;
   logic [CNT_W-1:0] load_cnt;

   assign pfx      = i_instr.done && (i_instr.kind != PFX_NONE);
   // A prefix blocks in the very cycle it completes, so nothing slips in behind it.
   assign lock_now = (cnt_q != CNT_ZERO) || pfx;
   assign cnt_dec  = i_instr.done && !pfx && (cnt_q != CNT_ZERO);
   assign trap_b_ok = i_req.trap_b;
   assign trap_a_ok = i_req.trap_a && !lock_now;
   assign irq_ok    = i_req.irq && !lock_now && (i_req.irq_prio > i_cpu_prio);
   assign pec_ok    = i_req.peripheral_event_transfer && !lock_now && !idle_lock_q;
   assign take_any  = (state_q == ST_RUN) && (trap_b_ok || trap_a_ok || irq_ok);

   // A count of zero still covers one instruction, and a count past the limit is cut to it,
   // so a stray pipeline value cannot hold interrupts off longer than the limit allows.
   always_comb begin
      if (i_instr.count == CNT_ZERO) begin
         load_cnt = CNT_ONE;
      end else if (i_instr.count > CNT_MAX) begin
         load_cnt = CNT_MAX;
      end else begin
         load_cnt = i_instr.count;
      end
   end

   // Extension counter: loaded by any prefix, reloaded when nested.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cnt_q <= CNT_ZERO;
      end else if (pfx) begin
         cnt_q <= load_cnt;
      end else if (cnt_dec) begin
         cnt_q <= cnt_q - CNT_ONE;
      end
   end

   // Override selection latched from the prefix.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         page_ov_q <= 1'b0;
         seg_ov_q  <= 1'b0;
         reg_ov_q  <= 1'b0;
         page_q    <= '0;
         seg_q     <= '0;
      end else if (pfx) begin
         page_ov_q <= (i_instr.kind == PFX_PAGE) || (i_instr.kind == PFX_PAGE_REG);
         seg_ov_q  <= (i_instr.kind == PFX_SEG) || (i_instr.kind == PFX_SEG_REG);
         reg_ov_q  <= (i_instr.kind == PFX_REG) || (i_instr.kind == PFX_PAGE_REG)
                      || (i_instr.kind == PFX_SEG_REG);
         page_q    <= i_instr.page;
         seg_q     <= i_instr.seg;
      end else if (cnt_dec && (cnt_q == CNT_ONE)) begin
         page_ov_q <= 1'b0;
         seg_ov_q  <= 1'b0;
         reg_ov_q  <= 1'b0;
      end
   end

   // Idle entered inside a lock keeps event transfers off until wake-up.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         idle_lock_q <= 1'b0;
      end else if (i_instr.done && i_instr.idle && (cnt_q != CNT_ZERO)) begin
         idle_lock_q <= 1'b1;
      end else if (take_any) begin
         idle_lock_q <= 1'b0;
      end
   end

   // Entry and return sequencer.
   // Requests are not latched: arbitration holds a request until the take pulse shows.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_q      <= ST_RUN;
         word_q       <= WORD_ZERO;
         vec_q        <= '0;
         o_push       <= 1'b0;
         o_pop        <= 1'b0;
         o_stack_word <= WORD_ZERO;
         o_branch     <= 1'b0;
         o_vector     <= '0;
         o_resume     <= 1'b0;
         o_take_irq   <= 1'b0;
         o_take_trap  <= 1'b0;
         o_abort_mul  <= 1'b0;
      end else begin
         o_branch    <= 1'b0;
         o_resume    <= 1'b0;
         o_take_irq  <= 1'b0;
         o_take_trap <= 1'b0;
         o_abort_mul <= 1'b0;
         case (state_q)
            ST_RUN: begin
               if (take_any) begin
                  state_q     <= ST_PUSH;
                  word_q      <= WORD_ZERO;
                  o_push      <= 1'b1;
                  o_stack_word <= WORD_ZERO;
                  o_take_trap <= trap_b_ok || trap_a_ok;
                  o_take_irq  <= !(trap_b_ok || trap_a_ok);
                  o_abort_mul <= i_mul_busy;
                  vec_q       <= trap_b_ok ? i_req.trap_b_vec :
                                 (trap_a_ok ? i_req.trap_a_vec : i_req.irq_vec);
               end else if (i_instr.done && i_instr.interrupt_return_instr) begin
                  state_q      <= ST_POP;
                  word_q       <= WORD_ZERO;
                  o_pop        <= 1'b1;
                  o_stack_word <= WORD_ZERO;
               end
            end
            // A stalled stack holds the word index, so no word is skipped or sent twice.
            ST_PUSH: begin
               if (i_stack_ready) begin
                  if (word_q == WORD_LAST) begin
                     state_q  <= ST_RUN;
                     o_push   <= 1'b0;
                     o_branch <= 1'b1;
                     o_vector <= vec_q;
                  end else begin
                     word_q       <= word_q + WORD_ONE;
                     o_stack_word <= word_q + WORD_ONE;
                  end
               end
            end
            ST_POP: begin
               if (i_stack_ready) begin
                  if (word_q == WORD_LAST) begin
                     state_q  <= ST_RUN;
                     o_pop    <= 1'b0;
                     o_resume <= 1'b1;
                  end else begin
                     word_q       <= word_q + WORD_ONE;
                     o_stack_word <= word_q + WORD_ONE;
                  end
               end
            end
            default: begin
               state_q <= ST_RUN;
               o_push  <= 1'b0;
               o_pop   <= 1'b0;
            end
         endcase
      end
   end

   // Event transfers and lock status, registered.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_locked   <= 1'b0;
         o_take_pec <= 1'b0;
      end else begin
         o_locked   <= lock_now;
         o_take_pec <= pec_ok && (state_q == ST_RUN) && !take_any;
      end
   end

   // Address formation, one cycle after the operand address is offered.
   // Page pointers are read live, so a pointer loaded just before already applies.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_phys_addr     <= '0;
         o_ext_reg_space <= 1'b0;
      end else begin
         if (seg_ov_q) begin
            o_phys_addr <= {seg_q, i_op_addr};
         end else if (page_ov_q) begin
            o_phys_addr <= {page_q, i_op_addr[PAGE_OFS_W-1:0]};
         end else begin
            o_phys_addr <= {i_op_addr[ADDR_W-1] ? i_page_ptr_hi[i_op_addr[ADDR_W-2]]
                                                : i_page_ptr[i_op_addr[ADDR_W-2]],
                            i_op_addr[PAGE_OFS_W-1:0]};
         end
         o_ext_reg_space <= i_short_mode && reg_ov_q;
      end
   end

   // Assertions: entry and return.
   irq_prio_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_take_irq |-> ($past(i_req.irq_prio) > $past(i_cpu_prio)))
      else $error("interrupt taken without higher priority");
   trap_a_take_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (i_req.trap_a && !lock_now && (state_q == ST_RUN)) |=> o_take_trap)
      else $error("trap not taken outside a lock");
   push_branch_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_branch |-> $past(o_push))
      else $error("branch without prior push");
   branch_vec_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_branch |-> (o_vector == $past(vec_q)))
      else $error("branch to the wrong vector");
   pop_start_a: assert property (@(posedge i_clk) disable iff (i_srst)
      ((state_q == ST_RUN) && !take_any && i_instr.done && i_instr.interrupt_return_instr) |=> o_pop)
      else $error("return did not start popping");
   pop_resume_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_resume |-> $past(o_pop))
      else $error("resume without pop");
   abort_mul_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (take_any && i_mul_busy) |=> o_abort_mul)
      else $error("busy multiply not aborted on entry");

   // Assertions: locking and the extension counter.
   prefix_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
      pfx |=> ((cnt_q >= CNT_ONE) && (cnt_q <= CNT_MAX)))
      else $error("counter load out of range");
   lock_irq_a: assert property (@(posedge i_clk) disable iff (i_srst)
      $past(lock_now) |-> (!o_take_irq && !o_take_pec))
      else $error("interrupt or transfer taken while locked");
   trap_a_lock_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (lock_now && !i_req.trap_b) |=> !o_take_trap)
      else $error("mild trap taken while locked");
   trap_b_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (i_req.trap_b && (state_q == ST_RUN)) |=> o_take_trap)
      else $error("severe trap not taken");
   block_now_a: assert property (@(posedge i_clk) disable iff (i_srst)
      pfx |=> o_locked)
      else $error("block not immediate");
   counter_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
      ((cnt_q != CNT_ZERO) && !i_instr.done) |=> (cnt_q == $past(cnt_q)))
      else $error("counter moved without a finished instruction");
   reload_a: assert property (@(posedge i_clk) disable iff (i_srst)
      ((cnt_q != CNT_ZERO) && pfx) |=> (cnt_q == $past(load_cnt)))
      else $error("nested prefix did not reload the counter");
   idle_pec_a: assert property (@(posedge i_clk) disable iff (i_srst)
      idle_lock_q |=> !o_take_pec)
      else $error("transfer granted in locked idle");
   expiry_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (cnt_dec && (cnt_q == CNT_ONE)) |=> (!reg_ov_q && !page_ov_q && !seg_ov_q))
      else $error("override outlived counter");
   expiry_cnt_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (cnt_dec && (cnt_q == CNT_ONE)) |=> (cnt_q == CNT_ZERO))
      else $error("counter did not run out");

   // Assertions: address formation and register space.
   normal_ofs_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (!page_ov_q && !seg_ov_q) |=> (o_phys_addr[PAGE_OFS_W-1:0] == $past(i_op_addr[PAGE_OFS_W-1:0])))
      else $error("page offset not carried through");
   page_num_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (page_ov_q && !seg_ov_q) |=> (o_phys_addr[PHYS_W-1:PAGE_OFS_W] == $past(page_q)))
      else $error("override page not applied");
   seg_ofs_a: assert property (@(posedge i_clk) disable iff (i_srst)
      seg_ov_q |=> (o_phys_addr[ADDR_W-1:0] == $past(i_op_addr)))
      else $error("segment offset not full width");
   ext_short_a: assert property (@(posedge i_clk) disable iff (i_srst)
      !i_short_mode |=> !o_ext_reg_space)
      else $error("long mode steered to extended space");
   ext_space_a: assert property (@(posedge i_clk) disable iff (i_srst)
      o_ext_reg_space |-> $past(reg_ov_q))
      else $error("extended space without prefix");
   combo_a: assert property (@(posedge i_clk) disable iff (i_srst)
      (pfx && ((i_instr.kind == PFX_PAGE_REG) || (i_instr.kind == PFX_SEG_REG)))
      |=> (reg_ov_q && (page_ov_q || seg_ov_q)))
      else $error("combined prefix missed one override");

   irq_cov_c: cover property (@(posedge i_clk) disable iff (i_srst) o_take_irq);
   nested_cov_c: cover property (@(posedge i_clk) disable iff (i_srst)
      (cnt_q != CNT_ZERO) && pfx);
   trap_lock_c: cover property (@(posedge i_clk) disable iff (i_srst)
      lock_now && i_req.trap_b);
   interrupt_return_instr_cov_c: cover property (@(posedge i_clk) disable iff (i_srst) o_resume);
   idle_pec_c: cover property (@(posedge i_clk) disable iff (i_srst) idle_lock_q && i_req.peripheral_event_transfer);

endmodule : locked_sequence_extension_control

// *** verif/stack_responder.sv ***
// Stack side model that answers the entry and return word handshake.
`timescale 1ns/1ps
module stack_responder (
   // Clock and reset.
   input  wire logic i_clk,
   input  wire logic i_srst,
   // Control.
   input  wire logic i_slow,
   // Handshake.
   output logic      o_ready
);
   // A slow stack stalls every other cycle, so the word index must hold.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_ready <= 1'b0;
      end else begin
         o_ready <= i_slow ? ~o_ready : 1'b1;
      end
   end
endmodule : stack_responder

// *** verif/tb_locked_sequence_extension_control.sv ***
// Testbench for the locked sequence and trap entry control.
`timescale 1ns/1ps
module tb_locked_sequence_extension_control;
   import lock_ctrl_pkg::*;
   logic                   i_clk, i_srst, i_mul_busy, i_short_mode, i_stack_ready, slow;
   instr_s                 i_instr;
   req_s                   i_req;
   logic [PRIO_W-1:0]      i_cpu_prio;
   logic [ADDR_W-1:0]      i_op_addr;
   logic [1:0][PAGE_W-1:0] i_page_ptr, i_page_ptr_hi;
   logic                   o_locked, o_take_irq, o_take_trap, o_take_pec, o_abort_mul;
   logic                   o_push, o_pop, o_branch, o_resume, o_ext_reg_space;
   logic [1:0]             o_stack_word;
   logic [VEC_W-1:0]       o_vector;
   logic [PHYS_W-1:0]      o_phys_addr;
   int                     num_errors, tests_run;

   locked_sequence_extension_control dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_instr(i_instr),
      .i_mul_busy(i_mul_busy), .i_cpu_prio(i_cpu_prio), .i_op_addr(i_op_addr), .i_short_mode(i_short_mode),
      .i_page_ptr(i_page_ptr), .i_page_ptr_hi(i_page_ptr_hi), .i_stack_ready(i_stack_ready), .i_req(i_req),
      .o_locked(o_locked), .o_take_irq(o_take_irq), .o_take_trap(o_take_trap), .o_take_pec(o_take_pec),
      .o_abort_mul(o_abort_mul), .o_push(o_push), .o_pop(o_pop), .o_stack_word(o_stack_word),
      .o_branch(o_branch), .o_vector(o_vector), .o_resume(o_resume), .o_phys_addr(o_phys_addr),
      .o_ext_reg_space(o_ext_reg_space));
   stack_responder stack_u (.i_clk(i_clk), .i_srst(i_srst), .i_slow(slow), .o_ready(i_stack_ready));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask : cyc

   // One completed instruction, a single-cycle pulse whatever its length.
   // A bubble follows, so back-to-back calls never rewrite the strobe in one time step.
   task automatic instr(input prefix_e k, input logic [2:0] c, input logic idle, input logic interrupt_return_instr);
      i_instr = '{1'b1, k, c, 10'h155, 8'h0f, idle, interrupt_return_instr};
      cyc(1);
      i_instr = '0;
      cyc(1);
   endtask : instr

   task automatic quiet(input int n);
      int t;
      t = 0;
      repeat (n) begin
         cyc(1);
         if (o_take_irq === 1'b1 || o_take_trap === 1'b1 || o_take_pec === 1'b1) t++;
      end
      chk(t, 0);
   endtask : quiet

   // Requests are not latched, so they stay up until the take pulse shows.
   task automatic entry(input logic [VEC_W-1:0] vec, input logic trap);
      int n;
      int w;
      n = 0;
      w = 0;
      while (o_take_irq !== 1'b1 && o_take_trap !== 1'b1 && n < 10) begin
         cyc(1);
         n++;
      end
      chk(n < 10, 1'b1);
      chk({o_take_trap, o_take_irq}, {trap, !trap});
      chk({o_push, o_stack_word}, 3'h4);
      chk(o_abort_mul, i_mul_busy);
      i_req = '0;
      n = 0;
      while (o_branch !== 1'b1 && n < 30) begin
         if (o_push === 1'b1 && i_stack_ready === 1'b1) w++;
         cyc(1);
         n++;
      end
      chk(n < 30, 1'b1);
      chk(w, 3);
      chk(o_vector, vec);
   endtask : entry

   task automatic t_prio();
      i_cpu_prio = 4'h5;
      i_req.irq = 1'b1;
      i_req.irq_prio = 4'h5;
      i_req.irq_vec = 8'h21;
      quiet(6);
      i_req.irq_prio = 4'h6;
      i_mul_busy = 1'b1;
      entry(8'h21, 1'b0);
      i_mul_busy = 1'b0;
   endtask : t_prio

   task automatic t_interrupt_return_instr();
      int n;
      instr(PFX_NONE, 3'h0, 1'b0, 1'b1);
      chk(o_pop, 1'b1);
      n = 0;
      while (o_resume !== 1'b1 && n < 30) begin
         cyc(1);
         n++;
      end
      chk(n < 30, 1'b1);
      chk(o_pop, 1'b0);
   endtask : t_interrupt_return_instr

   task automatic t_lock();
      slow = 1'b1;
      i_cpu_prio = 4'hf;
      i_req.trap_a = 1'b1;
      i_req.trap_a_vec = 8'h08;
      instr(PFX_ATOMIC, 3'h2, 1'b0, 1'b0);
      quiet(5);
      chk(o_locked, 1'b1);
      instr(PFX_NONE, 3'h0, 1'b0, 1'b0);
      instr(PFX_ATOMIC, 3'h4, 1'b0, 1'b0);
      repeat (3) instr(PFX_NONE, 3'h0, 1'b0, 1'b0);
      quiet(3);
      chk(o_locked, 1'b1);
      i_req.trap_b = 1'b1;
      i_req.trap_b_vec = 8'h0a;
      entry(8'h0a, 1'b1);
      instr(PFX_NONE, 3'h0, 1'b0, 1'b0);
      cyc(2);
      chk(o_locked, 1'b0);
      i_req.trap_a = 1'b1;
      i_req.trap_a_vec = 8'h08;
      entry(8'h08, 1'b1);
      slow = 1'b0;
   endtask : t_lock

   task automatic t_pec();
      i_req.peripheral_event_transfer = 1'b1;
      repeat (10) if (o_take_pec !== 1'b1) cyc(1);
      chk(o_take_pec, 1'b1);
      instr(PFX_ATOMIC, 3'h1, 1'b0, 1'b0);
      chk(o_take_pec, 1'b0);
      instr(PFX_NONE, 3'h0, 1'b1, 1'b0);
      quiet(8);
      i_req = '0;
   endtask : t_pec

   task automatic t_addr();
      prefix_e k;
      logic    pg, sg, rg;
      i_short_mode = 1'b1;
      i_op_addr = 16'hc123;
      cyc(2);
      chk(o_phys_addr, {10'h3c3, 14'h0123});
      i_op_addr = 16'h4123;
      cyc(2);
      chk(o_phys_addr, {10'h2a5, 14'h0123});
      chk(o_ext_reg_space, 1'b0);
      for (int j = 1; j < 7; j++) begin
         k = prefix_e'(j);
         pg = (k == PFX_PAGE || k == PFX_PAGE_REG);
         sg = (k == PFX_SEG || k == PFX_SEG_REG);
         rg = (k == PFX_REG || k == PFX_PAGE_REG || k == PFX_SEG_REG);
         instr(k, 3'h1, 1'b0, 1'b0);
         chk(o_phys_addr, sg ? {8'h0f, 16'h4123} : pg ? {10'h155, 14'h0123} : {10'h2a5, 14'h0123});
         chk(o_ext_reg_space, rg);
         chk(o_locked, 1'b1);
         instr(PFX_NONE, 3'h0, 1'b0, 1'b0);
         cyc(2);
         chk(o_phys_addr, {10'h2a5, 14'h0123});
         chk({o_locked, o_ext_reg_space}, 2'h0);
      end
   endtask : t_addr

   initial begin
      num_errors = 0;
      tests_run = 0;
      i_srst = 1'b1;
      i_instr = '0;
      i_req = '0;
      i_mul_busy = 1'b0;
      i_cpu_prio = 4'h0;
      i_op_addr = 16'h0;
      i_short_mode = 1'b0;
      i_page_ptr = {10'h2a5, 10'h011};
      i_page_ptr_hi = {10'h3c3, 10'h1f0};
      slow = 1'b0;
      cyc(4);
      i_srst = 1'b0;
      t_prio();
      t_interrupt_return_instr();
      t_lock();
      t_pec();
      t_addr();
      close_out();
   end

   // The whole sequence needs well under a thousand cycles.
   initial begin
      #100000;
      num_errors++;
      close_out();
   end
endmodule : tb_locked_sequence_extension_control
